// *** inc/legacy_stream_pkg.sv ***
package legacy_stream_pkg;

    localparam int          DATA_W      = 64;
    localparam int          USER_W      = 22;
    localparam int          ERRFWD_BIT  = 1;
    localparam int          START_LSB   = 10;
    localparam int          END_LSB     = 17;
    localparam int          POS_W       = 5;
    localparam int          LEN_W       = 11;
    localparam int          NP_SLOTS    = 4;
    // accept falls once free slots drop to this level
    localparam int          NP_HEADROOM = 2;

    localparam logic [4:0]  START_AT_DW0 = 5'h10;
    localparam logic [7:0]  KEEP64_FULL  = 8'hFF;

    localparam logic [4:0]  TYPE_MEM     = 5'h00;
    localparam logic [4:0]  TYPE_MEM_LK  = 5'h01;
    localparam logic [4:0]  TYPE_IO      = 5'h02;
    localparam logic [4:0]  TYPE_CFG0    = 5'h04;
    localparam logic [4:0]  TYPE_CFG1    = 5'h05;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_MOVE = 2'b01,
        RX_PAD  = 2'b11
    } rx_state_t;

    // first header dword in stream order: fmt [31:29], type [28:24]
    function automatic logic isNonposted(input logic [31:0] hdr);
        logic [2:0] fmt;
        logic [4:0] kind;
        fmt  = hdr[31:29];
        kind = hdr[28:24];
        return (kind == TYPE_IO) || (kind == TYPE_CFG0) || (kind == TYPE_CFG1)
            || (!fmt[1] && ((kind == TYPE_MEM) || (kind == TYPE_MEM_LK)));
    endfunction

endpackage

// *** inc/legacy_stream_if.sv ***
interface legacy_stream_if #(
    parameter int W = legacy_stream_pkg::DATA_W
);
    logic                                rxValid;
    logic                                rxReady;
    logic [W-1:0]                        rxData;
    logic [W/8-1:0]                      rxKeep;
    logic                                rxLast;
    logic [legacy_stream_pkg::USER_W-1:0] rxUser;
    logic                                rxNonpostedAccept;
    logic                                linkUp;
    logic                                txValid;
    logic                                txReady;
    logic [W-1:0]                        txData;
    logic [W/8-1:0]                      txKeep;
    logic                                txLast;

    modport device (
        output rxValid, rxData, rxKeep, rxLast, rxUser, linkUp, txReady,
        input  rxReady, rxNonpostedAccept, txValid, txData, txKeep, txLast
    );

    modport user (
        input  rxValid, rxData, rxKeep, rxLast, rxUser, linkUp, txReady,
        output rxReady, rxNonpostedAccept, txValid, txData, txKeep, txLast
    );
endinterface

// *** logic/stream_beat_framer.sv ***
module stream_beat_framer #(
    parameter int W = legacy_stream_pkg::DATA_W
) (
    input  wire logic [legacy_stream_pkg::LEN_W-1:0] remDw,
    input  wire logic                               first,
    output logic      [W/8-1:0]                     keep,
    output logic                                    last,
    output logic      [legacy_stream_pkg::POS_W-1:0] startPos,
    output logic      [legacy_stream_pkg::POS_W-1:0] endPos
);
    localparam int DW = W / 32;

    logic [2:0] beatDw;

    assign last   = remDw <= legacy_stream_pkg::LEN_W'(DW);
    assign beatDw = last ? remDw[2:0] : 3'(DW);

    genvar i;
    generate
        for (i = 0; i < W / 8; i++) begin : g_keep
            assign keep[i] = 3'(i / 4) < beatDw;
        end
    endgenerate

    // packets always open on dword 0 of a beat
    assign startPos = first ? legacy_stream_pkg::START_AT_DW0 : 5'h00;
    assign endPos   = last ? {1'b1, 2'(beatDw - 3'h1), 2'b11} : 5'h00;
endmodule

// *** logic/legacy_stream_device.sv ***
module legacy_stream_device #(
    parameter int W = legacy_stream_pkg::DATA_W
) (
    input  wire logic                                        core_clk,
    input  wire logic                                        rst_n,
    input  wire logic                                        ce,
    input  wire logic                                        linkUpIn,
    input  wire logic [1:0]                                  srcValid,
    input  wire logic [1:0][W-1:0]                           srcData,
    input  wire logic [1:0][legacy_stream_pkg::LEN_W-1:0]    srcLenDw,
    output logic      [1:0]                                  srcReady,
    output logic                                             sinkValid,
    output logic      [W-1:0]                                sinkData,
    output logic      [W/8-1:0]                              sinkKeep,
    output logic                                             sinkLast,
    input  wire logic                                        sinkReady,
    legacy_stream_if.device                                  bus
);
    localparam int DW   = W / 32;
    localparam int KW   = W / 8;
    localparam bit WIDE = (W == 128);
    localparam int START_HI = legacy_stream_pkg::START_LSB + legacy_stream_pkg::POS_W - 1;
    localparam int END_HI   = legacy_stream_pkg::END_LSB + legacy_stream_pkg::POS_W - 1;

    typedef struct packed {
        legacy_stream_pkg::rx_state_t          st;
        logic                                  lane;
        logic [legacy_stream_pkg::LEN_W-1:0]   rem;
        logic                                  first;
        logic                                  oValid;
        logic [W-1:0]                          oData;
        logic [KW-1:0]                         oKeep;
        logic                                  oLast;
        logic [legacy_stream_pkg::USER_W-1:0]  oUser;
        logic                                  sValid;
        logic [W-1:0]                          sData;
        logic [KW-1:0]                         sKeep;
        logic                                  sLast;
    } state_t;

    state_t s;
    state_t next_s;

    logic [W-1:0]                          laneSwap;
    logic [KW-1:0]                         fKeep;
    logic                                  fLast;
    logic [legacy_stream_pkg::POS_W-1:0]   fStart;
    logic [legacy_stream_pkg::POS_W-1:0]   fEnd;
    logic                                  advance;
    logic                                  takeTx;

    genvar d;
    generate
        for (d = 0; d < DW; d++) begin : g_swap
            assign laneSwap[32*d +: 32] = srcData[s.lane][32*(DW-1-d) +: 32];
        end
    endgenerate

    stream_beat_framer #(
        .W (W)
    ) u_framer (
        .remDw    (s.rem),
        .first    (s.first),
        .keep     (fKeep),
        .last     (fLast),
        .startPos (fStart),
        .endPos   (fEnd)
    );

    assign advance     = !s.oValid || bus.rxReady;
    assign bus.txReady = ce && (!s.sValid || sinkReady);
    assign takeTx      = bus.txValid && bus.txReady;

    always_comb begin
        next_s   = s;
        srcReady = 2'b00;
        if (advance) begin
            next_s.oValid = 1'b0;
        end
        case (s.st)
            legacy_stream_pkg::RX_IDLE: begin
                next_s.first = 1'b1;
                if (advance && linkUpIn) begin
                    if (srcValid[0]) begin
                        next_s.lane = 1'b0;
                        next_s.rem  = srcLenDw[0];
                        next_s.st   = legacy_stream_pkg::RX_MOVE;
                    end else if (srcValid[1] && bus.rxNonpostedAccept) begin
                        next_s.lane = 1'b1;
                        next_s.rem  = srcLenDw[1];
                        next_s.st   = legacy_stream_pkg::RX_MOVE;
                    end
                end
            end
            legacy_stream_pkg::RX_MOVE,
            legacy_stream_pkg::RX_PAD: begin
                if (advance && (!linkUpIn || s.st == legacy_stream_pkg::RX_PAD
                                || srcValid[s.lane])) begin
                    // link loss latches padding until the length runs out
                    if (!linkUpIn || s.st == legacy_stream_pkg::RX_PAD) begin
                        next_s.st    = legacy_stream_pkg::RX_PAD;
                        next_s.oData = '0;
                    end else begin
                        next_s.oData = laneSwap;
                    end
                    srcReady[s.lane] = ce && srcValid[s.lane];
                    next_s.oValid    = 1'b1;
                    next_s.oUser     = '0;
                    if (WIDE) begin
                        next_s.oKeep = '0;
                        next_s.oLast = 1'b0;
                        next_s.oUser[START_HI:legacy_stream_pkg::START_LSB] = fStart;
                        next_s.oUser[END_HI:legacy_stream_pkg::END_LSB]     = fEnd;
                    end else begin
                        next_s.oKeep = fKeep;
                        next_s.oLast = fLast;
                    end
                    next_s.first = 1'b0;
                    if (fLast) begin
                        next_s.st = legacy_stream_pkg::RX_IDLE;
                    end else begin
                        next_s.rem = s.rem - legacy_stream_pkg::LEN_W'(DW);
                    end
                end
            end
            default: begin
                next_s.st = legacy_stream_pkg::RX_IDLE;
            end
        endcase
        if (sinkReady) begin
            next_s.sValid = 1'b0;
        end
        if (takeTx) begin
            next_s.sValid = 1'b1;
            next_s.sData  = bus.txData;
            next_s.sKeep  = bus.txKeep;
            next_s.sLast  = bus.txLast;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s    <= '0;
            s.st <= legacy_stream_pkg::RX_IDLE;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign bus.rxValid = s.oValid;
    assign bus.rxData  = s.oData;
    assign bus.rxKeep  = s.oKeep;
    assign bus.rxLast  = s.oLast;
    assign bus.rxUser  = s.oUser;
    assign bus.linkUp  = linkUpIn;
    assign sinkValid   = s.sValid;
    assign sinkData    = s.sData;
    assign sinkKeep    = s.sKeep;
    assign sinkLast    = s.sLast;
endmodule

// *** logic/legacy_stream_user.sv ***
module legacy_stream_user #(
    parameter int W        = legacy_stream_pkg::DATA_W,
    parameter int NP_SLOTS = legacy_stream_pkg::NP_SLOTS
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    output logic                   legRxValid,
    input  wire logic              legRxReady,
    output logic      [W-1:0]      legRxData,
    output logic                   legRxEof_n,
    output logic      [1:0]        legRxRem,
    output logic                   legRxDsc_n,
    input  wire logic              npReorderEn,
    input  wire logic              npRelease,
    input  wire logic              legTxValid,
    output logic                   legTxReady,
    input  wire logic [W-1:0]      legTxData,
    input  wire logic              legTxEof_n,
    input  wire logic [1:0]        legTxRem_n,
    legacy_stream_if.user          bus
);
    localparam int DW   = W / 32;
    localparam int CW   = $clog2(NP_SLOTS + 1);
    localparam bit WIDE = (W == 128);

    typedef struct packed {
        logic          dsc_n;
        logic          accept;
        logic [CW-1:0] npFree;
        logic          inPkt;
    } state_t;

    state_t s;
    state_t next_s;

    logic [4:0] sp;
    logic [4:0] ep;
    logic       beat;
    logic       sop;
    logic       eof;
    logic [2:0] txDw;

    assign sp = bus.rxUser[legacy_stream_pkg::START_LSB +: legacy_stream_pkg::POS_W];
    assign ep = bus.rxUser[legacy_stream_pkg::END_LSB +: legacy_stream_pkg::POS_W];

    genvar d;
    generate
        for (d = 0; d < DW; d++) begin : g_swap
            assign legRxData[32*d +: 32]   = bus.rxData[32*(DW-1-d) +: 32];
            assign bus.txData[32*d +: 32]  = legTxData[32*(DW-1-d) +: 32];
        end
    endgenerate

    assign legRxValid  = bus.rxValid;
    assign bus.rxReady = ce && legRxReady;
    assign beat        = bus.rxValid && bus.rxReady;
    assign sop         = beat && (WIDE ? sp[4] : !s.inPkt);
    assign eof         = WIDE ? ep[4] : bus.rxLast;
    assign legRxEof_n  = !eof;

    // remainders only mean something while legRxEof_n is low
    always_comb begin
        if (WIDE) begin
            legRxRem[1] = (sp[4] && ep[4] && ep[3]) || (!sp[4] && ep[4] && ep[3])
                        || (sp[4] && !ep[4] && !sp[3]);
            legRxRem[0] = !ep[2];
        end else begin
            legRxRem[1] = 1'b0;
            legRxRem[0] = bus.rxLast ? (bus.rxKeep == legacy_stream_pkg::KEEP64_FULL) : 1'b1;
        end
    end

    // transmit keep is driven every cycle, covering both widths
    assign txDw = !legTxEof_n ? 3'(DW) - (WIDE ? {1'b0, legTxRem_n} : {2'b00, legTxRem_n[0]})
                              : 3'(DW);
    generate
        for (d = 0; d < W / 8; d++) begin : g_keep
            assign bus.txKeep[d] = 3'(d / 4) < txDw;
        end
    endgenerate
    assign bus.txValid = legTxValid;
    assign bus.txLast  = !legTxEof_n;
    assign legTxReady  = bus.txReady;

    always_comb begin
        next_s       = s;
        next_s.dsc_n = bus.linkUp;
        if (beat) begin
            next_s.inPkt = !bus.rxLast;
        end
        if (sop && legacy_stream_pkg::isNonposted(bus.rxData[31:0]) && s.npFree != '0) begin
            next_s.npFree = s.npFree - CW'(1);
        end
        if (npRelease && next_s.npFree != CW'(NP_SLOTS)) begin
            next_s.npFree = next_s.npFree + CW'(1);
        end
        // falls at the start of the third-to-last packet, well ahead of the second-to-last end
        next_s.accept = !npReorderEn
                     || (next_s.npFree > CW'(legacy_stream_pkg::NP_HEADROOM));
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s        <= '0;
            s.dsc_n  <= 1'b1;
            s.accept <= 1'b1;
            s.npFree <= CW'(NP_SLOTS);
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign legRxDsc_n            = s.dsc_n;
    assign bus.rxNonpostedAccept = s.accept;
endmodule

// *** test/legacy_stream_asserts.sv ***
module legacy_stream_asserts #(
    parameter int W = legacy_stream_pkg::DATA_W
) (
    input wire logic                                core_clk,
    input wire logic                                rst_n,
    input wire logic                                rxValid,
    input wire logic                                rxReady,
    input wire logic [W-1:0]                        rxData,
    input wire logic [W/8-1:0]                      rxKeep,
    input wire logic                                rxLast,
    input wire logic [legacy_stream_pkg::USER_W-1:0] rxUser,
    input wire logic                                rxNonpostedAccept,
    input wire logic                                linkUp,
    input wire logic                                txValid,
    input wire logic [W/8-1:0]                      txKeep,
    input wire logic                                txLast
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic inPkt;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            inPkt <= 1'b0;
        else if (rxValid && rxReady)
            inPkt <= !rxLast;
    end

    property p_rx_hold;
        rxValid && !rxReady |=> rxValid && $stable(rxData) && $stable(rxKeep);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx beat moved while stalled");
    property p_keep_shape;
        rxValid |-> rxKeep != 0 && ((rxKeep + 1'b1) & rxKeep) == 0;
    endproperty
    a_keep_shape: assert property (p_keep_shape) else $error("rx keep not low bytes");
    property p_keep_mid;
        rxValid && !rxLast |-> rxKeep == '1;
    endproperty
    a_keep_mid: assert property (p_keep_mid) else $error("rx keep short mid packet");
    property p_user_zero;
        rxValid |-> rxUser == '0;
    endproperty
    a_user_zero: assert property (p_user_zero) else $error("rx sideband set on 64 bit");
    property p_start_link;
        $rose(rxValid) |-> $past(linkUp, 2);
    endproperty
    a_start_link: assert property (p_start_link) else $error("packet began with link down");
    property p_pad_last;
        $fell(linkUp) && inPkt |-> ##[0:600] (rxValid && rxReady && rxLast);
    endproperty
    a_pad_last: assert property (p_pad_last) else $error("cut packet never ended");
    property p_tx_keep;
        txValid |-> (txLast ? (txKeep == 8'h0F || txKeep == 8'hFF) : txKeep == 8'hFF);
    endproperty
    a_tx_keep: assert property (p_tx_keep) else $error("tx keep wrong");
    property p_np_fall;
        $fell(rxNonpostedAccept) |-> $past(rxValid && rxReady && !inPkt);
    endproperty
    a_np_fall: assert property (p_np_fall) else $error("accept fell without a start");

    c_stall: cover property (rxValid && !rxReady);
    c_cut: cover property ($fell(linkUp) && inPkt);
    c_np_low: cover property ($fell(rxNonpostedAccept));
endmodule

// *** test/test_legacy_stream_strobe_adapter.sv ***
module test_legacy_stream_strobe_adapter;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int W = 64;
    logic            core_clk, rst_n, ce, linkUpIn, linkPrev, dataChk;
    logic [1:0]      srcValid, srcReady;
    logic [1:0][W-1:0] srcData;
    logic [1:0][10:0] srcLenDw;
    logic            sinkValid, sinkLast, sinkReady = 1'b1, legRxReady = 1'b1;
    logic [W-1:0]    sinkData, legRxData, legTxData;
    logic [7:0]      sinkKeep;
    logic            legRxValid, legRxEof_n, legRxDsc_n, npReorderEn, npRelease;
    logic [1:0]      legRxRem, legTxRem_n;
    logic            legTxValid, legTxReady, legTxEof_n;
    int              error_cnt, checks_done, seed, eofCnt, npBeats, k;
    logic [W-1:0]    rxQ[$];
    logic [1:0]      endQ[$];
    logic [72:0]     txQ[$];

    legacy_stream_if #(.W(W)) bus ();
    legacy_stream_device #(.W(W)) u_legacy_stream_device (.core_clk, .rst_n, .ce,
        .linkUpIn, .srcValid, .srcData, .srcLenDw, .srcReady, .sinkValid, .sinkData,
        .sinkKeep, .sinkLast, .sinkReady, .bus);
    legacy_stream_user #(.W(W)) u_legacy_stream_user (.core_clk, .rst_n, .ce, .legRxValid,
        .legRxReady, .legRxData, .legRxEof_n, .legRxRem, .legRxDsc_n, .npReorderEn,
        .npRelease, .legTxValid, .legTxReady, .legTxData, .legTxEof_n, .legTxRem_n, .bus);
    legacy_stream_asserts #(.W(W)) u_legacy_stream_asserts (.core_clk, .rst_n,
        .rxValid(bus.rxValid), .rxReady(bus.rxReady), .rxData(bus.rxData),
        .rxKeep(bus.rxKeep), .rxLast(bus.rxLast), .rxUser(bus.rxUser),
        .rxNonpostedAccept(bus.rxNonpostedAccept), .linkUp(bus.linkUp),
        .txValid(bus.txValid), .txKeep(bus.txKeep), .txLast(bus.txLast));

    task automatic chk(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            error_cnt++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task close_out;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // idles one cycle first so back-to-back calls never re-raise valid in one step;
    // a beat holds until the device takes it, so the header survives the select cycle
    task automatic send_pkt(input int lane, input int len);
        int left;
        int n;
        bit took;
        left = len;
        n = 0;
        @(negedge core_clk);
        srcLenDw[lane] = 11'(len);
        srcData[lane] = {$random(seed), $random(seed)};
        srcData[lane][63:56] = lane ? 8'h02 : 8'h40;
        srcValid[lane] = 1'b1;
        while (left > 0 && n < 400) begin
            @(posedge core_clk);
            n++;
            took = srcReady[lane];
            if (took) begin
                rxQ.push_back(srcData[lane]);
                left -= 2;
                endQ.push_back({left <= 0, left == 0});
            end
            if (!linkUpIn)
                left = 0;
            @(negedge core_clk);
            if (took)
                srcData[lane] = {$random(seed), $random(seed)};
        end
        srcValid[lane] = 1'b0;
        chk(n < 400, "source stuck");
    endtask

    task automatic tx_word(input bit eof);
        int n;
        n = 0;
        legTxValid = 1'b1;
        legTxData = {$random(seed), $random(seed)};
        legTxEof_n = !eof;
        legTxRem_n = 2'($random(seed));
        // ready is looked at on the very edge that takes the word
        @(posedge core_clk);
        while (!legTxReady && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        txQ.push_back({eof, (eof && legTxRem_n[0]) ? 8'h0F : 8'hFF,
                       legTxData[31:0], legTxData[63:32]});
        chk(n < 100, "sink stuck");
        @(negedge core_clk);
    endtask

    task automatic pulse_release(input int cnt);
        repeat (cnt) begin
            npRelease = 1'b1;
            @(negedge core_clk);
            npRelease = 1'b0;
            @(negedge core_clk);
        end
    endtask

    // ready lines move on the falling edge, settled at every sampling edge
    always @(negedge core_clk) begin
        legRxReady = 1'($random(seed));
        sinkReady = 1'($random(seed));
    end

    always @(posedge core_clk) begin
        logic [W-1:0] e;
        logic [1:0]   f;
        if (rst_n) begin
            chk(legRxDsc_n === linkPrev, "discontinue flag");
            if (srcReady[1])
                npBeats++;
            if (legRxValid && bus.rxReady && !legRxEof_n)
                eofCnt++;
            if (legRxValid && bus.rxReady && dataChk) begin
                chk(rxQ.size() > 0, "extra rx beat");
                e = rxQ.pop_front();
                f = endQ.pop_front();
                chk(bus.rxData === {e[31:0], e[63:32]}, "stream dword order");
                chk(legRxData === e, "legacy rx data");
                chk(legRxEof_n === !f[1], "legacy end flag");
                if (f[1])
                    chk(legRxRem === {1'b0, f[0]}, "legacy remainder");
            end
            if (sinkValid && sinkReady && ce)
                chk({sinkLast, sinkKeep, sinkData} === txQ.pop_front(), "tx word");
        end
        linkPrev = linkUpIn;
    end

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        close_out;
    end

    initial begin
        {rst_n, srcValid, srcData, srcLenDw, npReorderEn, npRelease} = '0;
        {legTxValid, legTxData, legTxRem_n, eofCnt, npBeats} = '0;
        {ce, linkUpIn, linkPrev, dataChk, legTxEof_n} = '1;
        seed = 32'hfe6e_9704;
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        fork
            for (int i = 0; i < 24; i++)
                send_pkt(0, i < 4 ? i + 1 : 1 + ($random(seed) & 15));
            begin
                repeat (40) tx_word(1'($random(seed)));
                legTxValid = 1'b0;
            end
        join
        for (int i = 0; i < 3; i++)
            send_pkt(1, 2);
        repeat (4) @(negedge core_clk);
        chk(bus.rxNonpostedAccept === 1'b1, "accept left high");
        pulse_release(3);
        npReorderEn = 1'b1;
        send_pkt(1, 3);
        send_pkt(1, 3);
        repeat (4) @(negedge core_clk);
        chk(bus.rxNonpostedAccept === 1'b0, "accept dropped early");
        k = npBeats;
        srcLenDw[1] = 11'h002;
        srcValid[1] = 1'b1;
        send_pkt(0, 4);
        repeat (20) @(negedge core_clk);
        chk(npBeats == k, "nonposted held back");
        srcValid[1] = 1'b0;
        pulse_release(2);
        send_pkt(1, 2);
        repeat (20) @(negedge core_clk);
        dataChk = 1'b0;
        k = eofCnt;
        fork
            send_pkt(0, 12);
            begin
                repeat (5) @(negedge core_clk);
                linkUpIn = 1'b0;
            end
        join
        repeat (60) @(negedge core_clk);
        chk(eofCnt == k + 1, "padded packet end");
        linkUpIn = 1'b1;
        rxQ.delete();
        endQ.delete();
        dataChk = 1'b1;
        // clock enable dropped mid packet: nothing may move while it is low
        fork
            send_pkt(0, 5);
            begin
                repeat (3) @(negedge core_clk);
                ce = 1'b0;
                repeat (4) @(negedge core_clk);
                chk(bus.rxReady === 1'b0 && bus.txReady === 1'b0, "ce freeze");
                ce = 1'b1;
            end
        join
        repeat (40) @(negedge core_clk);
        chk(rxQ.size() == 0 && txQ.size() == 0, "queues drained");
        close_out;
    end
endmodule
